// [src/selsc_core.sv]
// Overview of operation
// - link A extra-lane bits 7:1 turn on link-layer clocks of lanes 1..7.
// - link B extra-lane bits 7:1 turn on link-layer clocks of lanes 1..7.
// - serializer bit 0 keeps only clocks; 1 also powers extra-lane serializers.
// - extra lanes follow the link mode rate and test-pattern behaviour.
// - extra-only lanes send octet ramp when test selection is 0 or 5.
// - link A extra lanes stay off while channel power-down disables it.
// - link B extra lanes run only while link B itself is enabled.
// - serializer n is clocked only when lanes 0..n-1 are all enabled.
// - sync-header field: 0 sends CRC-12, 2 sends FEC, 1 and 3 reserved.
// - sync-header choice acts only in 64b/66b modes, ignored for 8b/10b.
// - no command channel; every command field of the sync word is zero.
module selsc_core
  import selsc_pkg::*;
(
  input  wire logic                         ref_clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [selsc_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [selsc_pkg::APB_DW-1:0] pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  input  wire logic [selsc_pkg::LANES-1:0]  mode_lanes_a_i,
  input  wire logic [selsc_pkg::LANES-1:0]  mode_lanes_b_i,
  input  wire logic                         mode_is_64b66b_i,
  input  wire logic [3:0]                   test_pattern_select_i,
  output logic                              pready_o,
  output logic [selsc_pkg::APB_DW-1:0]      prdata_o,
  output logic                              pslverr_o,
  output logic [selsc_pkg::LANES-1:0]       lane_clk_en_a_o,
  output logic [selsc_pkg::LANES-1:0]       lane_clk_en_b_o,
  output logic [selsc_pkg::LANES-1:0]       ser_pwr_en_a_o,
  output logic [selsc_pkg::LANES-1:0]       ser_pwr_en_b_o,
  output logic [selsc_pkg::LANES-1:0]       ser_clk_en_a_o,
  output logic [selsc_pkg::LANES-1:0]       ser_clk_en_b_o,
  output logic [selsc_pkg::LANES-1:0]       lane_ramp_a_o,
  output logic [selsc_pkg::LANES-1:0]       lane_ramp_b_o,
  output logic                              sync_crc12_o,
  output logic                              sync_fec_o,
  output logic [selsc_pkg::CMD_W-1:0]       sync_cmd_o
);
  import selsc_pkg::*;

  // ****************************************
  // helper functions
  // ****************************************

  // lanes a link drives: mode lanes plus requested extras while link is up
  function automatic logic [LANES-1:0] lanes_on(input logic             up,
                                                input logic [LANES-1:0] mode,
                                                input logic [LANES-1:0] extra);
    lanes_on = up ? (mode | extra) : '0;
  endfunction : lanes_on

  // serializer n only gets a clock when every lower lane is enabled
  function automatic logic [LANES-1:0] chain_ok(input logic [LANES-1:0] en);
    logic all_low;
    all_low  = 1'b1;
    chain_ok = '0;
    for (int n = 0; n < LANES; n++)
    begin
      chain_ok[n] = en[n] & all_low;
      all_low     = all_low & en[n];
    end
  endfunction : chain_ok

  // lanes that exist only through the extra field and must send a ramp
  function automatic logic [LANES-1:0] ramp_lanes(input logic [LANES-1:0] en,
                                                  input logic [LANES-1:0] mode,
                                                  input logic [3:0]       tsel);
    logic hit;
    hit        = (tsel == TEST_NONE) || (tsel == TEST_ALT);
    ramp_lanes = hit ? (en & ~mode) : '0;
  endfunction : ramp_lanes

  // ****************************************
  // register state
  // ****************************************
  logic [REG_W-1:0] link_ctrl_reg;
  logic [REG_W-1:0] chan_pd_reg;
  logic [REG_W-1:0] extra_a_reg;
  logic [REG_W-1:0] extra_b_reg;
  logic [REG_W-1:0] sync_hdr_reg;
  logic             pready_reg;
  logic [APB_DW-1:0] prdata_reg;
  logic             pslverr_reg;

  // ****************************************
  // bus decode
  // ****************************************
  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             setup_ph;
  logic             wr_take;
  logic             hit_map;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] wbyte;

  assign idx      = paddr_i[APB_AW-1:2];
  assign aligned  = (paddr_i[1:0] == BYTE_OFS);
  assign setup_ph = psel_i & ~penable_i;
  assign wbyte    = pwdata_i[REG_W-1:0];
  // write lands at the completing access edge only
  assign wr_take  = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg & pstrb_i[0];

  // ****************************************
  // lane state derived from configuration
  // ****************************************
  logic             link_a_up;
  logic             link_b_up;
  logic [LANES-1:0] extra_a_mask;
  logic [LANES-1:0] extra_b_mask;
  logic [LANES-1:0] ser_a_mask;
  logic [LANES-1:0] ser_b_mask;
  logic [LANES-1:0] clk_a_next;
  logic [LANES-1:0] clk_b_next;
  logic [LANES-1:0] pwr_a_next;
  logic [LANES-1:0] pwr_b_next;

  // power-down of a channel keeps that link and its extra lanes dark
  assign link_a_up = link_ctrl_reg[F_LINK_EN] & ~chan_pd_reg[F_PD_A];
  assign link_b_up = link_ctrl_reg[F_LINK_EN] & ~chan_pd_reg[F_PD_B];

  // bit 0 is the serializer switch, so lane 0 never comes from the field
  assign extra_a_mask = {extra_a_reg[LANES-1:1], 1'b0};
  assign extra_b_mask = {extra_b_reg[LANES-1:1], 1'b0};

  // extras reach the serializers only with the serializer switch set
  assign ser_a_mask = extra_a_mask & {LANES{extra_a_reg[F_SER_ON]}};
  assign ser_b_mask = extra_b_mask & {LANES{extra_b_reg[F_SER_ON]}};

  // link-layer clocks and serializer power per lane
  assign clk_a_next = lanes_on(link_a_up, mode_lanes_a_i, extra_a_mask);
  assign clk_b_next = lanes_on(link_b_up, mode_lanes_b_i, extra_b_mask);
  assign pwr_a_next = lanes_on(link_a_up, mode_lanes_a_i, ser_a_mask);
  assign pwr_b_next = lanes_on(link_b_up, mode_lanes_b_i, ser_b_mask);

  // ****************************************
  // read mux
  // ****************************************

  // unmapped or misaligned addresses answer with an error
  always_comb
  begin
    hit_map = aligned;
    rd_val  = RST_REG8;
    unique case (idx)
      IDX_LINK_CTRL:   rd_val = link_ctrl_reg;
      IDX_CHAN_PD:     rd_val = chan_pd_reg;
      IDX_EXTRA_A:     rd_val = extra_a_reg;
      IDX_EXTRA_B:     rd_val = extra_b_reg;
      IDX_SYNC_HDR:    rd_val = sync_hdr_reg;
      IDX_LANE_STAT_A: rd_val = lane_clk_en_a_o;
      IDX_LANE_STAT_B: rd_val = lane_clk_en_b_o;
      IDX_SER_STAT_A:  rd_val = ser_clk_en_a_o;
      IDX_SER_STAT_B:  rd_val = ser_clk_en_b_o;
      default:         hit_map = 1'b0;
    endcase
  end

  // ****************************************
  // apb response, one wait-free access cycle
  // ****************************************

  // ready rises in the first access cycle after each setup
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pready_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= setup_ph;
    end
  end

  // read data and error are captured in the setup cycle
  // and cleared at the next edge, so they never outlive ready
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_reg  <= (hit_map && !pwrite_i) ? {{(APB_DW-REG_W){1'b0}}, rd_val} : '0;
      pslverr_reg <= ~hit_map;
    end
    else
    begin
      prdata_reg  <= '0;  // answer stands for the access cycle only
      pslverr_reg <= 1'b0;
    end
  end

  assign pready_o  = pready_reg;
  assign prdata_o  = prdata_reg;
  assign pslverr_o = pslverr_reg;

  // ****************************************
  // writable registers
  // ****************************************

  // link enable and channel power-down
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      link_ctrl_reg <= RST_REG8;
      chan_pd_reg   <= RST_REG8;
    end
    else if (wr_take)
    begin
      if (idx == IDX_LINK_CTRL)
      begin
        link_ctrl_reg <= wbyte;
      end
      if (idx == IDX_CHAN_PD)
      begin
        chan_pd_reg <= wbyte;
      end
    end
  end

  // extra-lane fields, stored as written; software keeps the link off meanwhile
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      extra_a_reg <= RST_REG8;
      extra_b_reg <= RST_REG8;
    end
    else if (wr_take)
    begin
      if (idx == IDX_EXTRA_A)
      begin
        extra_a_reg <= wbyte;
      end
      if (idx == IDX_EXTRA_B)
      begin
        extra_b_reg <= wbyte;
      end
    end
  end

  // sync-header select, all eight bits read back as written
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_hdr_reg <= RST_REG8;
    end
    else if (wr_take && idx == IDX_SYNC_HDR)
    begin
      sync_hdr_reg <= wbyte;
    end
  end

  // ****************************************
  // lane enables toward the transmitter
  // ****************************************

  // link-layer clocks and serializer power, registered
  // a register change shows on the lanes one edge later
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lane_clk_en_a_o <= '0;
      lane_clk_en_b_o <= '0;
      ser_pwr_en_a_o  <= '0;
      ser_pwr_en_b_o  <= '0;
    end
    else
    begin
      lane_clk_en_a_o <= clk_a_next;
      lane_clk_en_b_o <= clk_b_next;
      ser_pwr_en_a_o  <= pwr_a_next;
      ser_pwr_en_b_o  <= pwr_b_next;
    end
  end

  // serializer clock gated by the lower-lane chain
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ser_clk_en_a_o <= '0;
      ser_clk_en_b_o <= '0;
    end
    else
    begin
      ser_clk_en_a_o <= chain_ok(pwr_a_next);
      ser_clk_en_b_o <= chain_ok(pwr_b_next);
    end
  end

  // extra-only lanes swap the normal pattern for the octet ramp at test selection 0 or 5;
  // other lanes keep the rate and pattern of the link mode
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      lane_ramp_a_o <= '0;
      lane_ramp_b_o <= '0;
    end
    else
    begin
      lane_ramp_a_o <= ramp_lanes(clk_a_next, mode_lanes_a_i, test_pattern_select_i);
      lane_ramp_b_o <= ramp_lanes(clk_b_next, mode_lanes_b_i, test_pattern_select_i);
    end
  end

  // ****************************************
  // sync word content
  // ****************************************

  // only 64b/66b modes use the choice; reserved codes select nothing
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_crc12_o <= 1'b0;
      sync_fec_o   <= 1'b0;
      sync_cmd_o   <= '0;
    end
    else
    begin
      sync_crc12_o <= mode_is_64b66b_i & (sync_hdr_reg[1:0] == SELSC_SH_CRC12);
      sync_fec_o   <= mode_is_64b66b_i & (sync_hdr_reg[1:0] == SELSC_SH_FEC);
      sync_cmd_o   <= '0;  // idle headers only
    end
  end

endmodule : selsc_core

// [src/selsc_pkg.sv]
package selsc_pkg;

  // ****************************************
  // bus geometry
  // ****************************************
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned IDX_W  = 10;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned LANES  = 8;
  localparam int unsigned CMD_W  = 19;

  // ****************************************
  // register indices, byte address is four times the index
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_LINK_CTRL    = 10'h200;
  localparam logic [IDX_W-1:0] IDX_CHAN_PD      = 10'h209;
  localparam logic [IDX_W-1:0] IDX_EXTRA_A      = 10'h20A;
  localparam logic [IDX_W-1:0] IDX_EXTRA_B      = 10'h20B;
  localparam logic [IDX_W-1:0] IDX_SYNC_HDR     = 10'h20F;
  localparam logic [IDX_W-1:0] IDX_LANE_STAT_A  = 10'h220;
  localparam logic [IDX_W-1:0] IDX_LANE_STAT_B  = 10'h221;
  localparam logic [IDX_W-1:0] IDX_SER_STAT_A   = 10'h222;
  localparam logic [IDX_W-1:0] IDX_SER_STAT_B   = 10'h223;

  // ****************************************
  // reset values and field positions
  // ****************************************
  localparam logic [REG_W-1:0] RST_REG8       = 8'h00;
  localparam int unsigned      F_SER_ON       = 0;
  localparam int unsigned      F_LINK_EN      = 0;
  localparam int unsigned      F_PD_A         = 0;
  localparam int unsigned      F_PD_B         = 1;
  localparam logic [1:0]       SH_MASK_W      = 2'h3;
  localparam logic [1:0]       BYTE_OFS       = 2'h0;

  // ****************************************
  // sync header choices and test selections
  // ****************************************
  typedef enum logic [1:0] {SELSC_SH_CRC12 = 2'h0, SELSC_SH_RSV1 = 2'h1,
                            SELSC_SH_FEC = 2'h2, SELSC_SH_RSV3 = 2'h3} selsc_sh_t;
  localparam logic [3:0] TEST_NONE = 4'h0;
  localparam logic [3:0] TEST_ALT  = 4'h5;

endpackage : selsc_pkg

// [verification/selsc_chk.sv]
module selsc_chk
  import selsc_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        mode_is_64b66b_i,
  input wire logic [3:0]  test_pattern_select_i,
  input wire logic [7:0]  mode_lanes_a_i,
  input wire logic [7:0]  lane_clk_en_a_o,
  input wire logic [7:0]  lane_clk_en_b_o,
  input wire logic [7:0]  ser_pwr_en_a_o,
  input wire logic [7:0]  ser_pwr_en_b_o,
  input wire logic [7:0]  ser_clk_en_a_o,
  input wire logic [7:0]  ser_clk_en_b_o,
  input wire logic [7:0]  lane_ramp_a_o,
  input wire logic        sync_crc12_o,
  input wire logic        sync_fec_o,
  input wire logic [18:0] sync_cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tsel_ok_reg;
  // ramp exception only for test selections 0 and 5
  always_ff @(posedge ref_clk_i)
  begin
    tsel_ok_reg <= (test_pattern_select_i == TEST_NONE) || (test_pattern_select_i == TEST_ALT);
  end
  // serializer clock chain: lane n needs all lower lanes powered
  function automatic logic [7:0] chain(input logic [7:0] p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      ok = ok & p[i];
      chain[i] = ok;
    end
  endfunction : chain
  // ********
  // properties
  // ********
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  property p_answer; s_setup |=> pready_o; endproperty
  property p_errrdy; pslverr_o |-> pready_o; endproperty
  property p_cmd; sync_cmd_o == '0; endproperty
  property p_sh8; !$past(mode_is_64b66b_i) |-> !(sync_crc12_o || sync_fec_o); endproperty
  property p_shx; !(sync_crc12_o && sync_fec_o); endproperty
  property p_lane0; lane_clk_en_a_o[0] |-> $past(mode_lanes_a_i[0]); endproperty
  property p_pwr; ((ser_pwr_en_a_o & ~lane_clk_en_a_o) | (ser_pwr_en_b_o & ~lane_clk_en_b_o)) == 8'h00; endproperty
  property p_chain; ser_clk_en_a_o == chain(ser_pwr_en_a_o) && ser_clk_en_b_o == chain(ser_pwr_en_b_o); endproperty
  property p_ramp; lane_ramp_a_o == (lane_clk_en_a_o & ~$past(mode_lanes_a_i) & {8{tsel_ok_reg}}); endproperty
  a_answer: assert property (p_answer) else $error("no ready after setup");
  a_errrdy: assert property (p_errrdy) else $error("error without ready");
  a_cmd: assert property (p_cmd) else $error("command field not zero");
  a_sh8: assert property (p_sh8) else $error("sync choice active in 8b10b");
  a_shx: assert property (p_shx) else $error("both sync contents");
  a_lane0: assert property (p_lane0) else $error("lane 0 not from mode");
  a_pwr: assert property (p_pwr) else $error("serializer without lane clocks");
  a_chain: assert property (p_chain) else $error("serializer clock chain wrong");
  a_ramp: assert property (p_ramp) else $error("ramp lanes wrong");
endmodule : selsc_chk

// [verification/selsc_rx_model.sv]
module selsc_rx_model
(
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] ser_clk_en_i,
  input  wire logic [7:0] ser_pwr_en_i,
  output logic      [7:0] live_lanes_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a lane carries data only when powered and clocked
  always_ff @(posedge ref_clk_i)
  begin
    live_lanes_o <= ser_clk_en_i & ser_pwr_en_i;
  end
endmodule : selsc_rx_model

// [verification/selsc_core_tb.sv]
bind selsc_core selsc_chk u_chk (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pready_o, .pslverr_o,
  .mode_is_64b66b_i, .test_pattern_select_i, .mode_lanes_a_i, .lane_clk_en_a_o, .lane_clk_en_b_o,
  .ser_pwr_en_a_o, .ser_pwr_en_b_o, .ser_clk_en_a_o, .ser_clk_en_b_o, .lane_ramp_a_o,
  .sync_crc12_o, .sync_fec_o, .sync_cmd_o);
module selsc_core_tb
  import selsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic        mode_is_64b66b_i = 1'b1;
  logic [3:0]  pstrb_i = 4'hF;
  logic [3:0]  test_pattern_select_i = 4'h0;
  logic [7:0]  mode_lanes_a_i = 8'h00;
  logic [7:0]  mode_lanes_b_i = 8'h00;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic        pready_o, pslverr_o, sync_crc12_o, sync_fec_o;
  logic [7:0]  lane_clk_en_a_o, lane_clk_en_b_o, ser_pwr_en_a_o, ser_pwr_en_b_o;
  logic [7:0]  ser_clk_en_a_o, ser_clk_en_b_o, lane_ramp_a_o, lane_ramp_b_o, live;
  logic [18:0] sync_cmd_o;
  logic [31:0] prdata_o;
  int          fails = 0;
  int          compares = 0;
  selsc_core DUT (.ref_clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
    .mode_lanes_a_i, .mode_lanes_b_i, .mode_is_64b66b_i, .test_pattern_select_i, .pready_o,
    .prdata_o, .pslverr_o, .lane_clk_en_a_o, .lane_clk_en_b_o, .ser_pwr_en_a_o, .ser_pwr_en_b_o,
    .ser_clk_en_a_o, .ser_clk_en_b_o, .lane_ramp_a_o, .lane_ramp_b_o, .sync_crc12_o, .sync_fec_o,
    .sync_cmd_o);
  selsc_rx_model RX (.ref_clk_i, .ser_clk_en_i(ser_clk_en_a_o), .ser_pwr_en_i(ser_pwr_en_a_o),
    .live_lanes_o(live));
  // 25 MHz clock
  initial
  begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge ref_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= {24'h0, d};
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'b1)
      @(posedge ref_clk_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, {i, 2'h0}, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 8'h00, q, e);
    chk(q, {24'h0, x});
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd
  // settings change only with the link disabled
  task automatic cfg(input logic [9:0] i, input logic [7:0] d);
    wr(IDX_LINK_CTRL, 8'h00);
    wr(i, d);
    wr(IDX_LINK_CTRL, 8'h01);
  endtask : cfg
  task automatic drive(input logic [7:0] ma, input logic [7:0] mb, input logic m, input logic [3:0] t);
    @(posedge ref_clk_i);
    mode_lanes_a_i        <= ma;
    mode_lanes_b_i        <= mb;
    mode_is_64b66b_i      <= m;
    test_pattern_select_i <= t;
  endtask : drive
  task automatic settle;
    repeat (3) @(negedge ref_clk_i);
  endtask : settle
  // ********
  // scenarios
  // ********
  task automatic t_regs;
    rd({IDX_EXTRA_A, 2'h0}, 8'h00, 1'b0);
    rd({IDX_EXTRA_B, 2'h0}, 8'h00, 1'b0);
    rd({IDX_SYNC_HDR, 2'h0}, 8'h00, 1'b0);
    rd(12'h7FC, 8'h00, 1'b1);
    rd({IDX_EXTRA_A, 2'h1}, 8'h00, 1'b1);
    pstrb_i <= 4'h0;
    wr(IDX_EXTRA_A, 8'h55);
    pstrb_i <= 4'hF;
    rd({IDX_EXTRA_A, 2'h0}, 8'h00, 1'b0);
  endtask : t_regs
  task automatic t_link_a;
    drive(8'h01, 8'h00, 1'b1, TEST_NONE);
    cfg(IDX_EXTRA_A, 8'hFE);
    settle;
    chk(lane_clk_en_a_o, 8'hFF);
    chk(ser_pwr_en_a_o, 8'h01);
    chk(lane_ramp_a_o, 8'hFE);
    drive(8'h01, 8'h00, 1'b1, 4'h4);
    settle;
    chk(lane_ramp_a_o, 8'h00);
    cfg(IDX_EXTRA_A, 8'h0B);
    settle;
    chk(ser_pwr_en_a_o, 8'h0B);
    chk(ser_clk_en_a_o, 8'h03);
    chk(live, 8'h03);
    cfg(IDX_CHAN_PD, 8'h01);
    settle;
    chk(lane_clk_en_a_o, 8'h00);
    chk(ser_pwr_en_a_o, 8'h00);
  endtask : t_link_a
  task automatic t_link_b;
    drive(8'h01, 8'h03, 1'b1, TEST_ALT);
    cfg(IDX_EXTRA_B, 8'h0D);
    settle;
    chk(lane_clk_en_b_o, 8'h0F);
    chk(ser_clk_en_b_o, 8'h0F);
    chk(lane_ramp_b_o, 8'h0C);
    cfg(IDX_EXTRA_B, 8'h30);
    settle;
    chk(lane_clk_en_b_o, 8'h33);
    chk(ser_pwr_en_b_o, 8'h03);
    rd({IDX_EXTRA_B, 2'h0}, 8'h30, 1'b0);
    cfg(IDX_CHAN_PD, 8'h02);
    settle;
    chk(lane_clk_en_b_o, 8'h00);
    chk(lane_clk_en_a_o, 8'h0B);
  endtask : t_link_b
  task automatic t_sync;
    for (int s = 0; s < 4; s++)
    begin
      cfg(IDX_SYNC_HDR, 8'(s));
      settle;
      chk({sync_crc12_o, sync_fec_o}, {s == 0, s == 2});
    end
    chk(sync_cmd_o, 19'h0);
    cfg(IDX_SYNC_HDR, 8'h02);
    drive(8'h01, 8'h03, 1'b0, TEST_NONE);
    settle;
    chk({sync_crc12_o, sync_fec_o}, 2'h0);
    drive(8'h01, 8'h03, 1'b1, TEST_NONE);
    settle;
    chk({sync_crc12_o, sync_fec_o}, 2'h1);
  endtask : t_sync
  // watchdog
  initial
  begin
    #100000;
    fails++;
    end_sim;
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_link_a;
    t_link_b;
    t_sync;
    end_sim;
  end
endmodule : selsc_core_tb
